/* logic/dss_freq_det.sv */
// Frequency threshold detector with hysteresis.
`timescale 1ns/1ps
module dss_freq_det
  import dss_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic [FREQ_W-1:0] freq_i,
  input  wire logic [FREQ_W-1:0] thresh_i,
  input  wire logic [FREQ_W-1:0] hyst_i,
  output logic                   det_o
);
  logic det_r;   // Detector state.
  logic det_nxt; // Next detector state.
  logic [FREQ_W:0] low_lvl; // Release level, floored at zero.

  // Set at threshold, release below threshold minus width.
  always_comb begin
    low_lvl = (thresh_i > hyst_i) ? {1'b0, thresh_i - hyst_i} : '0;
    det_nxt = det_r;
    if ({1'b0, freq_i} >= {1'b0, thresh_i}) begin
      det_nxt = 1'b1; // RULE20
    end else if ({1'b0, freq_i} < low_lvl) begin
      det_nxt = 1'b0; // RULE25
    end
  end

  // Register the detector.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      det_r <= 1'b0;
    end else begin
      det_r <= det_nxt;
    end
  end

  assign det_o = det_r;
endmodule // dss_freq_det

/* logic/dss_pkg.sv */
// Package of constants for the drive status-signal logic.
// Functional notes
// [RULE1] Ready on when prepared, stays on running.
// [RULE2] Running on at or above start frequency.
// [RULE3] Running-with-start when running and start active; code uses prepared instead of running.
// [RULE4] Running-with-start ignores fault and output stop.
// [RULE5] Shutoff: ready and running off, start passes.
// [RULE6] Coasting keeps ready except power loss; restart all on.
// [RULE7] Codes: ready 11/111, run 0/100, start 45/145.
// [RULE8] Codes below 100 conduct, 100-199 invert.
// [RULE9] Running code is default on running terminal.
// [RULE10] Trip asserts relay and held fault outputs.
// [RULE11] Held fault stays through reset period.
// [RULE12] Relay fault drops when fault reset.
// [RULE13] Held fault codes 94 and 194.
// [RULE14] Relay fault default on first relay contact.
// [RULE15] Contactor shutoff on internal or wiring fault.
// [RULE16] Only eleven listed fault types trigger shutoff.
// [RULE17] Contactor shutoff codes 91 and 191.
// [RULE18] Up-to-frequency within sensitivity band, default 10%.
// [RULE19] Band is set frequency times percent over 100.
// [RULE20] Primary detect at or above threshold, default 6Hz.
// [RULE21] Reverse threshold 9999 means use primary.
// [RULE22] Secondary detect at threshold, default 30Hz.
// [RULE23] Detect codes 4/104 and 5/105.
// [RULE24] Hysteresis width 0 to 5Hz, default 0.
// [RULE25] Detect drops below threshold minus hysteresis.
package dss_pkg;
  // Frequencies are in units of 0.01 Hz.
  localparam int unsigned FREQ_W      = 16;
  localparam int unsigned CODE_W      = 8;
  localparam int unsigned PCT_W       = 7;
  localparam int unsigned NUM_TERM    = 7;
  localparam int unsigned FAULT_W     = 16;
  // Assignment codes, positive form; negative form adds the offset.
  localparam logic [CODE_W-1:0] CODE_RUN      = 8'h00;
  localparam logic [CODE_W-1:0] CODE_FDET1    = 8'h04;
  localparam logic [CODE_W-1:0] CODE_FDET2    = 8'h05;
  localparam logic [CODE_W-1:0] CODE_READY    = 8'h0b;
  localparam logic [CODE_W-1:0] CODE_RUNSTART = 8'h2d;
  localparam logic [CODE_W-1:0] CODE_UPFREQ   = 8'h01;
  localparam logic [CODE_W-1:0] CODE_CONTACT  = 8'h5b;
  localparam logic [CODE_W-1:0] CODE_HELDFLT  = 8'h5e;
  localparam logic [CODE_W-1:0] CODE_RELAYFLT = 8'h63;
  localparam logic [CODE_W-1:0] CODE_NEG_OFS  = 8'h64;
  localparam logic [CODE_W-1:0] CODE_MAX      = 8'hc7;
  localparam logic [CODE_W-1:0] CODE_NONE     = 8'h27;
  // Terminal indexes with fixed default duties.
  localparam int unsigned TERM_RUN    = 0;
  localparam int unsigned TERM_RELAY1 = 5;
  // Setting defaults and limits.
  localparam logic [PCT_W-1:0]  SENS_DFLT   = 7'h0a;
  localparam logic [PCT_W-1:0]  SENS_MAX    = 7'h64;
  localparam logic [FREQ_W-1:0] FDET1_DFLT  = 16'h0258;
  localparam logic [FREQ_W-1:0] FDET2_DFLT  = 16'h0bb8;
  localparam logic [FREQ_W-1:0] FDET_MAX    = 16'h9c40;
  localparam logic [FREQ_W-1:0] REV_UNUSED  = 16'h270f;
  localparam logic [FREQ_W-1:0] HYST_MAX    = 16'h01f4;
  // Fault bit positions of the fault vector.
  localparam int unsigned F_INRUSH = 0;
  localparam int unsigned F_CPU_A  = 1;
  localparam int unsigned F_CPU_B  = 2;
  localparam int unsigned F_CPU_C  = 3;
  localparam int unsigned F_PSTO_A = 4;
  localparam int unsigned F_PSTO_B = 5;
  localparam int unsigned F_24V    = 6;
  localparam int unsigned F_PANEL  = 7;
  localparam int unsigned F_GROUND = 8;
  localparam int unsigned F_PHASE  = 9;
  localparam int unsigned F_BRAKE  = 10;
  localparam logic [FAULT_W-1:0] SHUTOFF_MASK = 16'h07ff;
endpackage : dss_pkg

/* logic/dss_status_top.sv */
// Drive status-signal generation and terminal routing.
`timescale 1ns/1ps
module dss_status_top
  import dss_pkg::*;
#(
  parameter int unsigned N_TERM = NUM_TERM
) (
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  input  wire logic                     prepared_i,        // Drive able to operate.
  input  wire logic                     start_cmd_i,       // Start command.
  input  wire logic                     output_stop_input_i,
  input  wire logic                     dc_brake_i,        // DC injection braking.
  input  wire logic                     coasting_i,        // Coasting before restart.
  input  wire logic                     restarting_i,      // Restart in progress.
  input  wire logic                     power_loss_i,      // Power failure or undervoltage.
  input  wire logic                     reverse_i,         // Reverse rotation.
  input  wire logic [FAULT_W-1:0]       fault_vec_i,       // Active trip causes.
  input  wire logic                     fault_reset_i,     // Fault reset in progress.
  input  wire logic [FREQ_W-1:0]        out_freq_i,
  input  wire logic [FREQ_W-1:0]        set_freq_i,
  input  wire logic [FREQ_W-1:0]        starting_frequency_setting_i,
  input  wire logic [PCT_W-1:0]         up_to_freq_sensitivity_i,
  input  wire logic [FREQ_W-1:0]        primary_detect_threshold_i,
  input  wire logic [FREQ_W-1:0]        reverse_detect_threshold_i,
  input  wire logic [FREQ_W-1:0]        secondary_detect_threshold_i,
  input  wire logic [FREQ_W-1:0]        detect_hysteresis_width_i,
  input  wire logic                     codes_load_i,      // Load new assignment codes.
  input  wire logic [N_TERM*CODE_W-1:0] terminal_assignment_codes_i,
  output logic                          operation_ready_o,
  output logic                          running_o,
  output logic                          running_with_start_o,
  output logic                          relay_fault_output_o,
  output logic                          held_fault_output_o,
  output logic                          contactor_shutoff_output_o,
  output logic                          up_to_frequency_o,
  output logic                          primary_freq_detect_o,
  output logic                          secondary_freq_detect_o,
  output logic [N_TERM-1:0]             term_o             // Terminal conduction.
);
  // Status flags, registered.
  logic ready_r, ready_nxt;
  logic run_r, run_nxt;
  logic rstart_r, rstart_nxt;
  logic relay_r, relay_nxt;
  logic held_r, held_nxt;
  logic contact_r, contact_nxt;
  logic upf_r, upf_nxt;
  // Assignment code store.
  logic [CODE_W-1:0] code_r   [N_TERM];
  logic [CODE_W-1:0] code_nxt [N_TERM];
  // Setting clamps.
  logic [FREQ_W-1:0] hyst_c;
  logic [FREQ_W-1:0] thr1_c;
  logic [FREQ_W-1:0] thr2_c;
  logic [FREQ_W-1:0] fdet1_thr;
  logic [PCT_W-1:0]  sens_c;
  logic [FREQ_W+PCT_W-1:0] band_prod;
  logic [FREQ_W:0]   band;
  logic [FREQ_W:0]   band_hi;
  logic [FREQ_W:0]   band_lo;
  logic              shutoff;
  logic              tripped;
  logic              fdet1, fdet2;
  logic [9:0]        funcs;

  // Clamp settings to their ranges; reverse threshold only when not unused.
  always_comb begin
    hyst_c = (detect_hysteresis_width_i > HYST_MAX) ? HYST_MAX : detect_hysteresis_width_i; // RULE24
    thr1_c = (primary_detect_threshold_i > FDET_MAX) ? FDET_MAX : primary_detect_threshold_i;
    thr2_c = (secondary_detect_threshold_i > FDET_MAX) ? FDET_MAX : secondary_detect_threshold_i;
    sens_c = (up_to_freq_sensitivity_i > SENS_MAX) ? SENS_MAX : up_to_freq_sensitivity_i;
    // The unused marker lies inside the range and is tested on the raw setting, before any clamp.
    if (reverse_i && (reverse_detect_threshold_i != REV_UNUSED)) begin
      fdet1_thr = (reverse_detect_threshold_i > FDET_MAX) ? FDET_MAX : reverse_detect_threshold_i; // RULE21
    end else begin
      fdet1_thr = thr1_c; // RULE21
    end
  end

  // Up-to-frequency band; the divide is a constant one, kept combinational.
  always_comb begin
    band_prod = set_freq_i * sens_c; // RULE19
    band      = {1'b0, FREQ_W'(band_prod / (FREQ_W+PCT_W)'(100))}; // RULE19
    band_hi   = {1'b0, set_freq_i} + band;
    band_lo   = ({1'b0, set_freq_i} > band) ? {1'b0, set_freq_i} - band : '0;
  end

  // Drive state decoding and fault logic.
  always_comb begin
    tripped     = |fault_vec_i;
    shutoff     = tripped || output_stop_input_i;
    ready_nxt   = 1'b0;
    run_nxt     = 1'b0;
    rstart_nxt  = 1'b0;
    if (restarting_i) begin
      ready_nxt  = 1'b1; // RULE6
      run_nxt    = 1'b1; // RULE6
      rstart_nxt = 1'b1; // RULE6
    end else if (shutoff) begin
      rstart_nxt = start_cmd_i; // RULE4 RULE5
    end else if (coasting_i) begin
      ready_nxt  = ~power_loss_i; // RULE6
      rstart_nxt = start_cmd_i;
    end else begin
      ready_nxt  = prepared_i; // RULE1
      // Running needs the start frequency reached and no DC braking.
      run_nxt    = (out_freq_i >= starting_frequency_setting_i) && !dc_brake_i && start_cmd_i; // RULE2
      // Running-with-start: drive prepared with start command held.
      rstart_nxt = start_cmd_i && prepared_i; // RULE3
    end
    relay_nxt   = tripped && !fault_reset_i; // RULE10 RULE12
    // Held output covers the whole reset window after a trip.
    held_nxt    = tripped || (held_r && fault_reset_i); // RULE10 RULE11
    // Only the listed internal or wiring faults open the contactor.
    contact_nxt = |(fault_vec_i & SHUTOFF_MASK); // RULE15 RULE16
    upf_nxt     = upf_r;
    // Hysteresis widens the band only for release.
    if (({1'b0, out_freq_i} >= band_lo) && ({1'b0, out_freq_i} <= band_hi)) begin
      upf_nxt = 1'b1; // RULE18
    end else if (({1'b0, out_freq_i} + {1'b0, hyst_c} < band_lo) ||
                 ({1'b0, out_freq_i} > band_hi + {1'b0, hyst_c})) begin
      upf_nxt = 1'b0; // RULE18
    end
  end

  // Code store: defaults at reset, loaded as a whole on request.
  always_comb begin
    for (int i = 0; i < N_TERM; i++) begin
      code_nxt[i] = codes_load_i ? terminal_assignment_codes_i[i*CODE_W +: CODE_W] : code_r[i];
    end
  end

  // Register status flags and codes.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ready_r   <= 1'b0;
      run_r     <= 1'b0;
      rstart_r  <= 1'b0;
      relay_r   <= 1'b0;
      held_r    <= 1'b0;
      contact_r <= 1'b0;
      upf_r     <= 1'b0;
      for (int i = 0; i < N_TERM; i++) begin
        if (i == TERM_RUN) begin
          code_r[i] <= CODE_RUN; // RULE9
        end else if (i == TERM_RELAY1) begin
          code_r[i] <= CODE_RELAYFLT; // RULE14
        end else begin
          code_r[i] <= CODE_NONE;
        end
      end
    end else begin
      ready_r   <= ready_nxt;
      run_r     <= run_nxt;
      rstart_r  <= rstart_nxt;
      relay_r   <= relay_nxt;
      held_r    <= held_nxt;
      contact_r <= contact_nxt;
      upf_r     <= upf_nxt;
      code_r    <= code_nxt;
    end
  end

  // Primary detector, direction-dependent threshold.
  dss_freq_det u_fdet1 (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .freq_i   (out_freq_i),
    .thresh_i (fdet1_thr),
    .hyst_i   (hyst_c),
    .det_o    (fdet1)
  );

  // Secondary detector.
  dss_freq_det u_fdet2 (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .freq_i   (out_freq_i),
    .thresh_i (thr2_c), // RULE22
    .hyst_i   (hyst_c),
    .det_o    (fdet2)
  );

  // Function vector in the order the selector decodes.
  assign funcs = {1'b0, relay_r, held_r, contact_r, upf_r, rstart_r, ready_r, fdet2, fdet1, run_r}; // RULE7 RULE13 RULE17 RULE23

  // One selector per terminal.
  for (genvar t = 0; t < N_TERM; t++) begin : g_term
    dss_term_map u_map (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .code_i (code_r[t]),
      .func_i (funcs),
      .term_o (term_o[t])
    );
  end

  assign operation_ready_o          = ready_r;
  assign running_o                  = run_r;
  assign running_with_start_o       = rstart_r;
  assign relay_fault_output_o       = relay_r;
  assign held_fault_output_o        = held_r;
  assign contactor_shutoff_output_o = contact_r;
  assign up_to_frequency_o          = upf_r;
  assign primary_freq_detect_o      = fdet1;
  assign secondary_freq_detect_o    = fdet2;
endmodule // dss_status_top

/* logic/dss_term_map.sv */
// Output terminal selector driven by an assignment code.
`timescale 1ns/1ps
module dss_term_map
  import dss_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic [CODE_W-1:0] code_i,
  input  wire logic [9:0]        func_i,
  output logic                   term_o
);
  logic              term_r;   // Registered terminal level.
  logic              term_nxt; // Next terminal level.
  logic [CODE_W-1:0] base;     // Code with negative offset removed.
  logic              neg;      // Negative logic selected.
  logic              act;      // Selected function level.

  // Decode code, pick the function and apply polarity.
  always_comb begin
    neg  = (code_i >= CODE_NEG_OFS) && (code_i <= CODE_MAX);
    base = neg ? code_i - CODE_NEG_OFS : code_i;
    unique case (base)
      CODE_RUN:      act = func_i[0];
      CODE_FDET1:    act = func_i[1];
      CODE_FDET2:    act = func_i[2];
      CODE_READY:    act = func_i[3];
      CODE_RUNSTART: act = func_i[4];
      CODE_UPFREQ:   act = func_i[5];
      CODE_CONTACT:  act = func_i[6];
      CODE_HELDFLT:  act = func_i[7];
      CODE_RELAYFLT: act = func_i[8];
      default:       act = 1'b0;
    endcase
    // Conduct when active below 100; invert for 100 to 199.
    if (code_i > CODE_MAX) begin
      term_nxt = 1'b0;
    end else if (neg) begin
      term_nxt = ~act; // RULE8
    end else begin
      term_nxt = act; // RULE8
    end
  end

  // Register so terminals never glitch.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      term_r <= 1'b0;
    end else begin
      term_r <= term_nxt;
    end
  end

  assign term_o = term_r;
endmodule // dss_term_map

/* testbench/dss_equip_model.sv */
// Model of the external equipment wired to the drive's output terminals.
`timescale 1ns/1ps
module dss_equip_model #(
  parameter int unsigned N_TERM = 7
) (
  input  wire logic [N_TERM-1:0] term_i,  // Terminal conduction from the drive.
  output logic      [N_TERM-1:0] lamp_o   // Load energised per terminal.
);
  // A load sees current only while its contact or transistor conducts.
  assign lamp_o = term_i;
endmodule // dss_equip_model

/* testbench/dss_status_checker.sv */
// Concurrent checks on the status outputs of the drive status-signal logic.
`timescale 1ns/1ps
module dss_status_checker
  import dss_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               nrst_i,
  input wire logic               start_cmd_i,
  input wire logic               output_stop_input_i,
  input wire logic               coasting_i,
  input wire logic               restarting_i,
  input wire logic               power_loss_i,
  input wire logic               reverse_i,
  input wire logic [FAULT_W-1:0] fault_vec_i,
  input wire logic               fault_reset_i,
  input wire logic [FREQ_W-1:0]  out_freq_i,
  input wire logic [FREQ_W-1:0]  primary_detect_threshold_i,
  input wire logic [FREQ_W-1:0]  secondary_detect_threshold_i,
  input wire logic               operation_ready_o,
  input wire logic               running_o,
  input wire logic               running_with_start_o,
  input wire logic               relay_fault_output_o,
  input wire logic               held_fault_output_o,
  input wire logic               contactor_shutoff_output_o,
  input wire logic               primary_freq_detect_o,
  input wire logic               secondary_freq_detect_o
);
  // All checks live in the single clock domain and are quiet during reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Any trip cause at all.
  wire flt_c = |fault_vec_i;
  // Only the listed internal or wiring causes open the input contactor.
  wire cut_c = |(fault_vec_i & SHUTOFF_MASK);
  // Output shutoff comes from a trip or from the output-stop input.
  wire shut_c = flt_c | output_stop_input_i;

  a_shut_ready: assert property (shut_c && !restarting_i |=> !operation_ready_o && !running_o)
    else $error("ready or running stayed on during shutoff");
  a_restart_on: assert property (restarting_i |=> operation_ready_o && running_o && running_with_start_o)
    else $error("status outputs not all on while restarting");
  a_rws_start: assert property (!restarting_i |=> running_with_start_o == $past(start_cmd_i))
    else $error("running-with-start does not follow the start command");
  a_coast_ready: assert property (coasting_i && !shut_c && !restarting_i |=>
    operation_ready_o == !$past(power_loss_i) && !running_o)
    else $error("ready wrong while coasting");
  a_relay_flt: assert property (1'b1 |=> relay_fault_output_o == ($past(flt_c) && !$past(fault_reset_i)))
    else $error("relay fault output wrong");
  a_held_keep: assert property (held_fault_output_o && fault_reset_i |=> held_fault_output_o)
    else $error("held fault dropped during reset period");
  a_held_drop: assert property (!flt_c && !fault_reset_i |=> !held_fault_output_o)
    else $error("held fault stayed on after reset release");
  a_contact_cut: assert property (1'b1 |=> contactor_shutoff_output_o == $past(cut_c))
    else $error("contactor shutoff output wrong");
  a_fdet2_on: assert property (out_freq_i >= secondary_detect_threshold_i |=> secondary_freq_detect_o)
    else $error("secondary detect missing at threshold");
  a_fdet1_fwd: assert property (!reverse_i && out_freq_i >= primary_detect_threshold_i |=> primary_freq_detect_o)
    else $error("primary detect missing in forward rotation");

  // Main scenarios that the bench must reach.
  c_restart: cover property (restarting_i);
  c_held: cover property (held_fault_output_o && fault_reset_i);
  c_cut: cover property (contactor_shutoff_output_o);
endmodule // dss_status_checker

bind dss_status_top dss_status_checker u_chk (.*);

/* testbench/dss_status_top_tb.sv */
// Self-checking bench for the drive status-signal logic.
`timescale 1ns/1ps
module dss_status_top_tb import dss_pkg::*; ;
  logic clk_i, nrst_i, prepared_i, start_cmd_i, output_stop_input_i, dc_brake_i, coasting_i, hi;
  logic restarting_i, power_loss_i, reverse_i, fault_reset_i, codes_load_i;
  logic [FAULT_W-1:0] fault_vec_i;
  logic [FREQ_W-1:0] out_freq_i, set_freq_i, starting_frequency_setting_i, primary_detect_threshold_i;
  logic [FREQ_W-1:0] reverse_detect_threshold_i, secondary_detect_threshold_i, detect_hysteresis_width_i;
  logic [PCT_W-1:0] up_to_freq_sensitivity_i;
  logic [NUM_TERM*CODE_W-1:0] terminal_assignment_codes_i;
  logic operation_ready_o, running_o, running_with_start_o, relay_fault_output_o, held_fault_output_o;
  logic contactor_shutoff_output_o, up_to_frequency_o, primary_freq_detect_o, secondary_freq_detect_o;
  logic [NUM_TERM-1:0] term_o, lamp;
  int errors = 0, samples_checked = 0, cyc = 0;
  // Rows: prepared, start, stop, brake, coast, restart, power loss, high freq; then ready, run, run-with-start.
  logic [10:0] rows [11] = '{11'h000, 11'h404, 11'h605, 11'h60f, 11'h68d, 11'h709,
                             11'h508, 11'h64d, 11'h458, 11'h12f, 11'h40c};
  // Codes with the level every terminal must show while running with no fault.
  logic [8:0] ctab [14] = '{9'h10b, 9'h06f, 9'h100, 9'h064, 9'h12d, 9'h091, 9'h05e,
                            9'h1c2, 9'h05b, 9'h1bf, 9'h104, 9'h068, 9'h105, 9'h069};

  dss_status_top dut (.*);
  dss_equip_model #(.N_TERM(NUM_TERM)) load (.term_i(term_o), .lamp_o(lamp));

  // Free-running 40 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Cuts a hang short; the whole run needs well under a thousand cycles.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      print_verdict();
    end
  end

  // Waits for n edges, then lets that edge's updates land.
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  // Compares one observed value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [6:0] exp, input logic [6:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    {prepared_i, start_cmd_i, output_stop_input_i, dc_brake_i, coasting_i, hi} = '0;
    {restarting_i, power_loss_i, reverse_i, fault_reset_i, codes_load_i, nrst_i} = '0;
    fault_vec_i = '0;
    out_freq_i = '0;
    set_freq_i = 16'h0fa0;
    starting_frequency_setting_i = 16'h01f4;
    up_to_freq_sensitivity_i = SENS_DFLT;
    primary_detect_threshold_i = FDET1_DFLT;
    reverse_detect_threshold_i = REV_UNUSED;
    secondary_detect_threshold_i = FDET2_DFLT;
    detect_hysteresis_width_i = '0;
    terminal_assignment_codes_i = '0;
    step(6);
    chk("reset outputs", 7'h00, {1'b0, operation_ready_o, running_o, relay_fault_output_o, term_o[2:0]});
    nrst_i = 1'b1;
    // Status table over every drive state.
    for (int i = 0; i < 11; i++) begin
      {prepared_i, start_cmd_i, output_stop_input_i, dc_brake_i, coasting_i, restarting_i, power_loss_i, hi} = rows[i][10:3];
      out_freq_i = hi ? 16'h0fa0 : 16'h0000;
      step(2);
      chk("status", {4'h0, rows[i][2:0]}, {4'h0, operation_ready_o, running_o, running_with_start_o});
    end
    $display("status table done");
    // Running state; default codes put running on terminal 0 only.
    {prepared_i, start_cmd_i, output_stop_input_i, restarting_i} = 4'hc;
    step(3);
    chk("default terms", 7'h01, lamp);
    // A wiring trip with start held: shutoff, both fault outputs, contactor open.
    fault_vec_i = 16'h0001 << F_GROUND;
    step(3);
    chk("trip", 7'h0f, {1'b0, operation_ready_o, running_o, running_with_start_o, relay_fault_output_o,
        held_fault_output_o, contactor_shutoff_output_o});
    chk("relay terminal", 7'h20, lamp);
    for (int b = 0; b < 16; b++) begin
      fault_vec_i = 16'h0001 << b;
      step(2);
      chk("shutoff cause", 7'(b < 11), {6'h00, contactor_shutoff_output_o});
    end
    fault_reset_i = 1'b1;
    fault_vec_i = '0;
    step(2);
    chk("in reset", 7'h01, {5'h00, relay_fault_output_o, held_fault_output_o});
    fault_reset_i = 1'b0;
    step(2);
    chk("released", 7'h00, {5'h00, relay_fault_output_o, held_fault_output_o});
    $display("fault outputs done");
    // Every assignment code except up-to-frequency and relay fault, in both logic senses on all terminals.
    foreach (ctab[i]) begin
      terminal_assignment_codes_i = {NUM_TERM{ctab[i][7:0]}};
      codes_load_i = 1'b1;
      step(1);
      codes_load_i = 1'b0;
      step(3);
      chk("terminal code", {NUM_TERM{ctab[i][8]}}, lamp);
    end
    $display("terminal codes done");
    // Threshold detection with a one hertz hysteresis.
    detect_hysteresis_width_i = 16'h0064;
    out_freq_i = 16'h0bb8;
    step(2);
    chk("fdet2 on", 7'h01, {6'h00, secondary_freq_detect_o});
    out_freq_i = 16'h0b86;
    step(2);
    chk("fdet2 hold", 7'h01, {6'h00, secondary_freq_detect_o});
    out_freq_i = 16'h0b53;
    step(2);
    chk("fdet2 off", 7'h00, {6'h00, secondary_freq_detect_o});
    reverse_i = 1'b1;
    reverse_detect_threshold_i = 16'h04b0;
    out_freq_i = 16'h03e8;
    step(2);
    chk("reverse thr", 7'h00, {6'h00, primary_freq_detect_o});
    reverse_detect_threshold_i = REV_UNUSED;
    step(2);
    chk("reverse unused", 7'h01, {6'h00, primary_freq_detect_o});
    // Up-to-frequency: 50 Hz set, ten percent band, released beyond band plus hysteresis.
    set_freq_i = 16'h1388;
    out_freq_i = 16'h1518;
    step(2);
    chk("upf in band", 7'h01, {6'h00, up_to_frequency_o});
    out_freq_i = 16'h1644;
    step(2);
    chk("upf out", 7'h00, {6'h00, up_to_frequency_o});
    out_freq_i = 16'h11c6;
    step(2);
    chk("upf low side", 7'h01, {6'h00, up_to_frequency_o});
    $display("frequency detection done");
    // A second reset in mid-run clears the outputs at once.
    nrst_i = 1'b0;
    #3;
    chk("mid reset", 7'h00, {1'b0, operation_ready_o, running_with_start_o, up_to_frequency_o, term_o[2:0]});
    step(2);
    nrst_i = 1'b1;
    $display("mid-run reset done");
    print_verdict();
  end
endmodule // dss_status_top_tb
